// *** rtl/imwc_ctrl.v ***
// Overview of operation
// - idle sleep: stop cpu, peripherals keep clock
// - idle keeps slow osc, secondary osc running
// - idle exits only irq, watchdog, reset
// - wake waits start delay, resumes same source
// - wake leaves idle select and source
// - watchdog in idle/sleep wakes to run
// - primary idle keeps primary ready flag
// - secondary idle: primary off, secondary flag
// - secondary idle without enable ignores sleep
// - secondary not running: withhold peripheral clocks
// - secondary idle wake stays on secondary
// - internal idle: primary off, flag cleared
// - fast osc enabled, stable after interval
// - already stable fast osc stays flagged
// - all select bits clear: fast osc off
// - internal wake resumes internal, slow kept
// - only enabled irq flags start wake
// - irq wake vectors when global enable set
// - watchdog timeout in run gives reset
// - four events clear watchdog and postscaler
// - reset exit waits primary ready
// - two-speed/fail-safe start on internal osc
// - sleep without idle stops osc, clears flags
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "imwc_defs.vh"

module imwc_ctrl #(
   parameter NIRQ     = 8,
   parameter TCSD_CYC = `IMWC_TCSD_CYC,
   parameter TIOB_CYC = `IMWC_FSTB_CYC,
   parameter WDT_CNT  = `IMWC_WDT_CNT,
   parameter WDT_POST = `IMWC_WDT_POST
) (
   input  wire            core_clk,
   input  wire            reset,
   // register port
   input  wire [3:0]      reg_addr,
   input  wire [31:0]     reg_wdata,
   input  wire            reg_wr,
   input  wire            reg_rd,
   output reg  [31:0]     reg_rdata,
   // processor instruction strobes
   input  wire            sleep_exec,
   input  wire            wdt_clr_exec,
   // interrupt flags from peripherals
   input  wire [NIRQ-1:0] irq_flags,
   // oscillator status
   input  wire            primary_clk_ready,
   input  wire            sec_osc_running,
   input  wire            clock_loss,
   // clock gating and oscillator controls
   output reg             cpu_clk_en,
   output reg             periph_clk_en,
   output reg             primary_osc_en,
   output reg             sec_osc_keep,
   output reg             slow_osc_en,
   output reg             fast_osc_en,
   output reg  [1:0]      active_src,
   // events to the processor
   output reg             irq_vector_take,
   output reg             wdt_reset_out
);

   // the sequencer tracks where the processor stands:
   // hold waits for the start-up timer after reset,
   // run executes, idle keeps peripherals clocked,
   // sleep stops cpu and peripheral clocks, wake counts the start delay
   // one-hot mode states
   localparam [4:0] ST_HOLD  = 5'h01;
   localparam [4:0] ST_RUN   = 5'h02;
   localparam [4:0] ST_IDLE  = 5'h04;
   localparam [4:0] ST_SLEEP = 5'h08;
   localparam [4:0] ST_WAKE  = 5'h10;

   // terminal counts, worked out at full width first
   localparam [31:0] TCSD_W  = TCSD_CYC - 1;
   localparam [31:0] TIOB_W  = TIOB_CYC - 1;
   localparam [31:0] WCNT_W  = WDT_CNT - 1;
   localparam [31:0] WPST_W  = WDT_POST - 1;
   // counters are 16 bits wide; larger counts are not supported
   localparam [15:0] TCSD_M1 = TCSD_W[15:0];
   localparam [15:0] TIOB_M1 = TIOB_W[15:0];
   localparam [15:0] WCNT_M1 = WCNT_W[15:0];
   localparam [15:0] WPST_M1 = WPST_W[15:0];

   reg  [11:0]     ctrl_r;        // software control word
   reg  [NIRQ-1:0] irq_en_r;      // per-source wake enables
   reg  [4:0]      state_r;       // current mode
   reg  [1:0]      src_r;         // source of the current mode
   reg  [15:0]     dly_r;         // start delay counter
   reg  [15:0]     stb_r;         // fast osc stabilise counter
   reg  [15:0]     wcnt_r;        // watchdog counter
   reg  [15:0]     wpst_r;        // watchdog postscaler
   reg             pri_flag_r;    // primary ready flag
   reg             fast_flag_r;   // fast osc stable flag
   reg             sec_flag_r;    // secondary running flag
   reg             boot_int_r;    // two-speed start on internal osc
   reg             by_irq_r;      // current wake came from interrupt
   reg  [2:0]      ifs_d_r;       // last frequency select value

   // control word fields
   wire       idle_select_bit  = ctrl_r[`IMWC_CTRL_IDLE];
   wire [1:0] clk_src_sel      = ctrl_r[`IMWC_CTRL_SRC_HI:`IMWC_CTRL_SRC_LO];
   wire [2:0] internal_freq_select = ctrl_r[`IMWC_CTRL_IFS_MSB:`IMWC_CTRL_IFS_LSB];
   wire       low_source_select = ctrl_r[`IMWC_CTRL_LOWSRC];
   wire       secondary_osc_enable = ctrl_r[`IMWC_CTRL_SECEN];
   wire       global_irq_enable = ctrl_r[`IMWC_CTRL_GIE];
   wire       wdt_en           = ctrl_r[`IMWC_CTRL_WDTEN];
   wire       fscm_en          = ctrl_r[`IMWC_CTRL_FSCM];
   wire       two_spd_en       = ctrl_r[`IMWC_CTRL_TWOSPD];

   // upper select bit alone picks the internal source; lower is ignored
   wire       sel_int  = clk_src_sel[1];
   wire       sel_sec  = (clk_src_sel == `IMWC_SRC_SEC);
   wire       src_int  = src_r[1];
   wire       src_sec  = (src_r == `IMWC_SRC_SEC);

   // an interrupt wakes only through its enable; the flag itself
   // is a level from the peripheral, so a held flag re-wakes at once
   // after the next sleep unless software clears it first
   // wake sources
   wire       irq_wake = |(irq_flags & irq_en_r);
   wire       wdt_hit  = wdt_en && (wcnt_r == WCNT_M1) && (wpst_r == WPST_M1);
   wire       in_run   = state_r[1];
   wire       asleep   = state_r[2] | state_r[3];

   // a sleep with secondary idle and no oscillator enable is dropped
   wire       sleep_ok = sleep_exec && in_run &&
                         !(idle_select_bit && sel_sec && !secondary_osc_enable);

   // fast oscillator request follows the frequency select and low select
   wire       fast_req = (internal_freq_select != 3'h0) | low_source_select;

   // watchdog clear events
   wire       ifs_chg  = (internal_freq_select != ifs_d_r) && src_int;
   wire       wdt_clr  = sleep_ok | wdt_clr_exec |
                         (clock_loss & fscm_en) | ifs_chg;

   // the status word has no write path: its flags are hardware-owned,
   // so no set/clear collision can arise between software and logic
   // register writes and the frequency history
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         ctrl_r   <= `IMWC_CTRL_RST;
         irq_en_r <= {NIRQ{1'b0}};
         ifs_d_r  <= 3'h0;
      end
      else
      begin
         ifs_d_r <= internal_freq_select;
         // only software writes change select bits; wake never does
         if (reg_wr && reg_addr == `IMWC_ADDR_CTRL)
            ctrl_r <= reg_wdata[11:0];
         if (reg_wr && reg_addr == `IMWC_ADDR_IRQEN)
            irq_en_r <= reg_wdata[NIRQ-1:0];
      end
   end

   // reads have no side effects, so a polling loop is harmless
   // read data, one cycle after the strobe, zero elsewhere
   always @(posedge core_clk)
   begin
      if (reset)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
      begin
         case (reg_addr)
            `IMWC_ADDR_CTRL:  reg_rdata <= {20'h00000, ctrl_r};
            `IMWC_ADDR_STAT:  reg_rdata <= {23'h000000, state_r, 1'b0,
                                            sec_flag_r, fast_flag_r, pri_flag_r};
            `IMWC_ADDR_IRQEN: reg_rdata <= {{(32-NIRQ){1'b0}}, irq_en_r};
            default:          reg_rdata <= 32'h00000000;
         endcase
      end
      else
         reg_rdata <= 32'h00000000;
   end

   // the counter wraps the postscaler; a hit clears both so that a
   // wake by time-out gives a full period before the next one
   // held at zero while disabled, so enabling starts a fresh period
   // watchdog counter with postscaler
   always @(posedge core_clk)
   begin
      if (reset || wdt_clr || wdt_hit || !wdt_en)
      begin
         wcnt_r <= 16'h0000;
         wpst_r <= 16'h0000;
      end
      else if (wcnt_r == WCNT_M1)
      begin
         wcnt_r <= 16'h0000;
         wpst_r <= wpst_r + 16'h0001;
      end
      else
         wcnt_r <= wcnt_r + 16'h0001;
   end

   // the timer only models the settling interval; the real
   // oscillator is outside this block and assumed to settle in time
   // full sleep drops the output, so the flag must be earned again
   // fast oscillator stabilise timer; kept if already stable
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         stb_r       <= 16'h0000;
         fast_flag_r <= 1'b0;
      end
      else if (!fast_req || state_r[3])
      begin
         // output off: no stable indication
         stb_r       <= 16'h0000;
         fast_flag_r <= 1'b0;
      end
      else if (!fast_flag_r)
      begin
         // flag only after the full interval; clocks run meanwhile
         if (stb_r == TIOB_M1)
            fast_flag_r <= 1'b1;
         else
            stb_r <= stb_r + 16'h0001;
      end
      // a stable flag simply holds through idle entry
   end

   // sleep is only taken in run; a strobe in any other mode is
   // dropped rather than queued, since the processor is not running
   // then and cannot have issued it.
   // the source is latched at entry and at wake; the select field
   // is never written here, so software sees its own setting back
   // mode sequencer
   always @(posedge core_clk)
   begin
      if (reset)
      begin
         state_r         <= ST_HOLD;
         src_r           <= `IMWC_SRC_PRI;
         dly_r           <= 16'h0000;
         pri_flag_r      <= 1'b0;
         sec_flag_r      <= 1'b0;
         boot_int_r      <= 1'b0;
         by_irq_r        <= 1'b0;
         irq_vector_take <= 1'b0;
         wdt_reset_out   <= 1'b0;
      end
      else
      begin
         irq_vector_take <= 1'b0;
         wdt_reset_out   <= 1'b0;
         case (state_r)
            ST_HOLD:
            begin
               // held by the start-up timer unless two-speed start or the fail-safe monitor is enabled
               if (two_spd_en || fscm_en)
               begin
                  src_r      <= 2'h2;
                  boot_int_r <= 1'b1;
                  state_r    <= ST_RUN;
               end
               else if (primary_clk_ready)
               begin
                  pri_flag_r <= 1'b1;
                  state_r    <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               // primary came up during two-speed start: switch over
               if (boot_int_r && primary_clk_ready)
               begin
                  boot_int_r <= 1'b0;
                  src_r      <= `IMWC_SRC_PRI;
                  pri_flag_r <= 1'b1;
               end
               if (wdt_hit)
                  wdt_reset_out <= 1'b1;
               else if (sleep_ok)
               begin
                  // a power-managed entry ends two-speed start
                  boot_int_r <= 1'b0;
                  src_r      <= clk_src_sel;
                  if (!idle_select_bit)
                  begin
                     pri_flag_r <= 1'b0;
                     sec_flag_r <= 1'b0;
                     state_r    <= ST_SLEEP;
                  end
                  else
                  begin
                     state_r <= ST_IDLE;
                     if (sel_int)
                     begin
                        pri_flag_r <= 1'b0;
                        sec_flag_r <= 1'b0;
                     end
                     else if (sel_sec)
                     begin
                        pri_flag_r <= 1'b0;
                        sec_flag_r <= 1'b1;
                     end
                     else
                     begin
                        pri_flag_r <= primary_clk_ready;
                        sec_flag_r <= 1'b0;
                     end
                  end
               end
            end
            ST_IDLE, ST_SLEEP:
            begin
               // nothing else resumes the processor
               if (irq_wake || wdt_hit)
               begin
                  by_irq_r <= irq_wake;
                  src_r    <= clk_src_sel;
                  dly_r    <= 16'h0000;
                  state_r  <= ST_WAKE;
               end
            end
            ST_WAKE:
            begin
               // start delay, plus primary ready when resuming on the primary
               if (dly_r != TCSD_M1)
                  dly_r <= dly_r + 16'h0001;
               else if (src_int || src_sec || primary_clk_ready)
               begin
                  state_r <= ST_RUN;
                  if (!src_int && !src_sec)
                     pri_flag_r <= 1'b1;
                  if (src_sec)
                     sec_flag_r <= 1'b1;
                  if (by_irq_r && global_irq_enable)
                     irq_vector_take <= 1'b1;
               end
            end
            default:
               state_r <= ST_HOLD;
         endcase
      end
   end

   // all gates except periph_clk_en, which also takes sec_osc_running, are decoded from registered state so they are glitch
   // free within a cycle; the oscillators themselves are external and
   // only see these enables as levels
   // clock gates and oscillator enables
   always @*
   begin
      // processor clock only in run mode
      cpu_clk_en     = in_run;
      // peripherals run in idle; secondary must be oscillating
      periph_clk_en  = (in_run | state_r[2] | state_r[4]) &&
                       !(src_sec && !sec_osc_running);
      // primary stays on only when it is the source or during two-speed start
      primary_osc_en = !state_r[3] && (!src_int && !src_sec || boot_int_r)
                       || state_r[0] || (state_r[4] && !src_int && !src_sec);
      // secondary keeps running whenever enabled
      sec_osc_keep   = secondary_osc_enable;
      // slow osc for watchdog or fail-safe monitor
      slow_osc_en    = wdt_en | fscm_en;
      // fast output while selected; off in full sleep
      fast_osc_en    = fast_req && !state_r[3];
      // resume on the source of the idle mode just left
      active_src     = src_r;
   end

endmodule
`default_nettype wire

// *** rtl/imwc_defs.vh ***
`ifndef IMWC_DEFS_VH
`define IMWC_DEFS_VH

// register word addresses (byte address, one 32-bit word each)
`define IMWC_ADDR_CTRL      4'h0
`define IMWC_ADDR_STAT      4'h4
`define IMWC_ADDR_IRQEN     4'h8

// control word field positions
`define IMWC_CTRL_IDLE      0
`define IMWC_CTRL_SRC_LO    1
`define IMWC_CTRL_SRC_HI    2
`define IMWC_CTRL_IFS_LSB   3
`define IMWC_CTRL_IFS_MSB   5
`define IMWC_CTRL_LOWSRC    6
`define IMWC_CTRL_SECEN     7
`define IMWC_CTRL_GIE       8
`define IMWC_CTRL_WDTEN     9
`define IMWC_CTRL_FSCM      10
`define IMWC_CTRL_TWOSPD    11

// status word field positions
`define IMWC_STAT_PRIRDY    0
`define IMWC_STAT_FASTSTB   1
`define IMWC_STAT_SECRUN    2
`define IMWC_STAT_MODE_LSB  4

// clock source select encodings
`define IMWC_SRC_PRI        2'h0
`define IMWC_SRC_SEC        2'h1

// reset value of the control word
`define IMWC_CTRL_RST       12'h000

// timing: figures in ns, cycles derived from the clock rate
`define IMWC_CLK_MHZ        100
`define IMWC_TCSD_NS        2000
`define IMWC_FSTB_NS        1000
`define IMWC_TCSD_CYC       ((`IMWC_TCSD_NS * `IMWC_CLK_MHZ + 999) / 1000)
`define IMWC_FSTB_CYC       ((`IMWC_FSTB_NS * `IMWC_CLK_MHZ + 999) / 1000)

// watchdog period in cycles (counter times postscaler)
`define IMWC_WDT_CNT        256
`define IMWC_WDT_POST       16

`endif

// *** dv/imwc_ctrl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module imwc_ctrl_monitor #(
   parameter TCSD_CYC = 200,
   parameter WDT_CNT  = 256,
   parameter WDT_POST = 16
) (
   input wire       core_clk,
   input wire       reset,
   input wire       sleep_exec,
   input wire       wdt_clr_exec,
   input wire       cpu_clk_en,
   input wire       periph_clk_en,
   input wire       primary_osc_en,
   input wire       sec_osc_running,
   input wire [1:0] active_src,
   input wire       irq_vector_take,
   input wire       wdt_reset_out
);
   // cycles since watchdog was last cleared; other clear causes only make it looser
   reg [15:0]       gap_r;
   always @(posedge core_clk)
   begin
      if (reset || sleep_exec || wdt_clr_exec)
         gap_r <= 16'h0000;
      else if (gap_r != 16'hFFFF)
         gap_r <= gap_r + 16'h0001;
   end
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   run_clocks_a: assert property (cpu_clk_en |-> periph_clk_en)
      else $error("cpu clocked without peripherals");
   primary_idle_a: assert property (!cpu_clk_en && periph_clk_en && active_src == 2'h0
      |-> primary_osc_en) else $error("primary osc off in primary idle");
   alt_idle_a: assert property (!cpu_clk_en && periph_clk_en && active_src != 2'h0
      |-> !primary_osc_en) else $error("primary osc left on in idle");
   sec_wait_a: assert property (!cpu_clk_en && !primary_osc_en && active_src == 2'h1
      && !sec_osc_running |-> !periph_clk_en) else $error("peripherals clocked early");
   wake_delay_a: assert property ($rose(cpu_clk_en) |-> !$past(cpu_clk_en, TCSD_CYC))
      else $error("cpu resumed before start delay");
   vector_a: assert property (irq_vector_take |-> $rose(cpu_clk_en))
      else $error("vector pulse not at resume");
   wdt_run_a: assert property (wdt_reset_out |-> $past(cpu_clk_en))
      else $error("watchdog reset outside run");
   wdt_gap_a: assert property (wdt_reset_out |-> gap_r >= WDT_CNT * WDT_POST - 2)
      else $error("watchdog fired too soon after clear");
endmodule
bind imwc_ctrl imwc_ctrl_monitor #(
   .TCSD_CYC (TCSD_CYC),
   .WDT_CNT  (WDT_CNT),
   .WDT_POST (WDT_POST)
) i_imwc_ctrl_monitor (
   .core_clk        (core_clk),
   .reset           (reset),
   .sleep_exec      (sleep_exec),
   .wdt_clr_exec    (wdt_clr_exec),
   .cpu_clk_en      (cpu_clk_en),
   .periph_clk_en   (periph_clk_en),
   .primary_osc_en  (primary_osc_en),
   .sec_osc_running (sec_osc_running),
   .active_src      (active_src),
   .irq_vector_take (irq_vector_take),
   .wdt_reset_out   (wdt_reset_out)
);
`default_nettype wire

// *** dv/imwc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "imwc_defs.vh"
module imwc_ctrl_tb_top;
   localparam TCSD = 4;
   logic        core_clk, reset, reg_wr, reg_rd, sleep_exec, wdt_clr_exec;
   logic        primary_clk_ready, sec_osc_running, clock_loss;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [7:0]  irq_flags;
   logic        cpu_clk_en, periph_clk_en, primary_osc_en, sec_osc_keep;
   logic        slow_osc_en, fast_osc_en, irq_vector_take, wdt_reset_out;
   logic [1:0]  active_src;
   int          errors, samples_checked, vec_cnt, rst_cnt, cyc, n;
   // short counts keep the run brief
   imwc_ctrl #(.NIRQ(8), .TCSD_CYC(TCSD), .TIOB_CYC(4), .WDT_CNT(8), .WDT_POST(2))
   i_imwc_ctrl (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sleep_exec(sleep_exec), .wdt_clr_exec(wdt_clr_exec), .irq_flags(irq_flags),
      .primary_clk_ready(primary_clk_ready), .sec_osc_running(sec_osc_running),
      .clock_loss(clock_loss), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
      .primary_osc_en(primary_osc_en), .sec_osc_keep(sec_osc_keep),
      .slow_osc_en(slow_osc_en), .fast_osc_en(fast_osc_en), .active_src(active_src),
      .irq_vector_take(irq_vector_take), .wdt_reset_out(wdt_reset_out));
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // pulse counters and hang guard
   always @(posedge core_clk)
   begin
      cyc++;
      if (irq_vector_take === 1'b1) vec_cnt++;
      if (wdt_reset_out === 1'b1) rst_cnt++;
      if (cyc == 5000)
      begin
         errors++;
         end_sim;
      end
   end
   task end_sim;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask
   task rd_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task slp;
      @(posedge core_clk);
      sleep_exec <= 1'b1;
      @(posedge core_clk);
      sleep_exec <= 1'b0;
      #1;
   endtask
   // bounded wait for the processor clock to come back
   task wait_run;
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 60)
      begin
         @(posedge core_clk);
         #1 n++;
      end
   endtask
   task wake;
      @(posedge core_clk);
      irq_flags <= 8'h01;
      wait_run;
      chk({31'h0, n > TCSD && n < TCSD + 3}, 32'h1);
      @(posedge core_clk);
      irq_flags <= 8'h00;
      // let the pulse counters update before the caller looks
      #1;
   endtask
   initial
   begin
      {reset, reg_wr, reg_rd, sleep_exec, wdt_clr_exec} = 5'h1F;
      {reg_wr, reg_rd, sleep_exec, wdt_clr_exec} = 4'h0;
      {primary_clk_ready, sec_osc_running, clock_loss} = 3'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      irq_flags = 8'h00;
      {errors, samples_checked, vec_cnt, rst_cnt, cyc} = '0;
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      // held until the primary clock reports ready
      repeat (4) @(posedge core_clk);
      rd_chk(`IMWC_ADDR_STAT, 32'h10);
      chk(cpu_clk_en, 32'h0);
      @(posedge core_clk);
      primary_clk_ready <= 1'b1;
      repeat (3) @(posedge core_clk);
      rd_chk(`IMWC_ADDR_STAT, 32'h21);
      rd_chk(`IMWC_ADDR_CTRL, 32'h0);
      wr(`IMWC_ADDR_STAT, 32'hFFF);
      rd_chk(`IMWC_ADDR_STAT, 32'h21);
      rd_chk(4'hC, 32'h0);
      $display("reset test done");
      // primary idle, disabled source first, then vectored wake
      wr(`IMWC_ADDR_IRQEN, 32'h1);
      wr(`IMWC_ADDR_CTRL, 32'h101);
      irq_flags <= 8'h02;
      slp;
      chk({29'h0, cpu_clk_en, periph_clk_en, primary_osc_en}, 32'h3);
      rd_chk(`IMWC_ADDR_STAT, 32'h41);
      repeat (10) @(posedge core_clk);
      chk(cpu_clk_en, 32'h0);
      wake;
      chk(vec_cnt, 32'h1);
      rd_chk(`IMWC_ADDR_CTRL, 32'h101);
      rd_chk(`IMWC_ADDR_STAT, 32'h21);
      $display("primary idle test done");
      // full sleep, no vector without global enable
      wr(`IMWC_ADDR_CTRL, 32'h0);
      slp;
      chk({30'h0, cpu_clk_en, periph_clk_en}, 32'h0);
      rd_chk(`IMWC_ADDR_STAT, 32'h80);
      wake;
      chk(vec_cnt, 32'h1);
      rd_chk(`IMWC_ADDR_STAT, 32'h21);
      $display("sleep test done");
      // internal idle, lower select bit set but ignored
      wr(`IMWC_ADDR_CTRL, 32'h7);
      slp;
      chk({29'h0, fast_osc_en, primary_osc_en, active_src[1]}, 32'h1);
      rd_chk(`IMWC_ADDR_STAT, 32'h40);
      wake;
      chk(active_src[1], 32'h1);
      wr(`IMWC_ADDR_CTRL, 32'h47);
      slp;
      chk(periph_clk_en, 32'h1);
      repeat (6) @(posedge core_clk);
      rd_chk(`IMWC_ADDR_STAT, 32'h42);
      chk(fast_osc_en, 32'h1);
      wake;
      slp;
      rd_chk(`IMWC_ADDR_STAT, 32'h42);
      wake;
      $display("internal idle test done");
      // clears every five cycles keep a sixteen-cycle watchdog quiet
      wr(`IMWC_ADDR_CTRL, 32'h200);
      repeat (6)
      begin
         @(posedge core_clk);
         wdt_clr_exec <= 1'b1;
         @(posedge core_clk);
         wdt_clr_exec <= 1'b0;
         repeat (3) @(posedge core_clk);
      end
      chk(rst_cnt, 32'h0);
      // secondary idle: refused without enable, then watchdog wake
      wr(`IMWC_ADDR_CTRL, 32'h3);
      slp;
      chk(cpu_clk_en, 32'h1);
      wr(`IMWC_ADDR_CTRL, 32'h283);
      slp;
      chk({28'h0, cpu_clk_en, periph_clk_en, primary_osc_en, sec_osc_keep}, 32'h1);
      chk(slow_osc_en, 32'h1);
      @(posedge core_clk);
      sec_osc_running <= 1'b1;
      @(posedge core_clk);
      #1 chk(periph_clk_en, 32'h1);
      rd_chk(`IMWC_ADDR_STAT, 32'h44);
      wait_run;
      chk({cpu_clk_en, rst_cnt[30:0]}, 32'h80000000);
      chk(active_src, 32'h1);
      // left running, the watchdog must now reset instead of waking
      n = 0;
      while (rst_cnt == 0 && n < 40)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      chk(rst_cnt > 0, 32'h1);
      $display("secondary idle test done");
      end_sim;
   end
endmodule
`default_nettype wire
